// file: core/cbs_pkg.sv
package cbs_pkg;
	localparam int          NCELL       = 12;
	localparam int          NLOC        = 13;
	localparam int          CLK_HZ      = 250_000_000;
	localparam int          PAUSE_MS    = 10;
	localparam int          ON_STEP_S   = 20;
	localparam int          SEC_CYC     = CLK_HZ;
	localparam int          PAUSE_CYC   = PAUSE_MS * (CLK_HZ / 1000);
	// Register word indices; byte address is four times the index
	localparam logic [5:0]  IDX_SETUP   = 6'h13;
	localparam logic [5:0]  IDX_PATTERN = 6'h14;
	localparam logic [5:0]  IDX_WDBT    = 6'h15;
	localparam logic [5:0]  IDX_DEVSET  = 6'h19;
	localparam logic [5:0]  IDX_BVAL_LO = 6'h20;
	localparam logic [5:0]  IDX_BVAL_HI = 6'h37;
	// Balance setup fields
	localparam int          MODE_LSB    = 0;
	localparam int          WAIT_LSB    = 2;
	localparam int          PTR_LSB     = 5;
	localparam int          BEN_BIT     = 9;
	localparam logic [13:0] SETUP_MASK  = 14'h03ff;
	localparam logic [13:0] SETUP_RST   = 14'h0000;
	// Watchdog and balance time fields
	localparam int          WDG_LSB     = 0;
	localparam int          WDX_BIT     = 6;
	localparam int          BTM_LSB     = 7;
	localparam logic [13:0] WDBT_MASK   = 14'h3fff;
	localparam logic [13:0] WDBT_RST    = 14'h0000;
	// Device setup fields
	localparam int          EOB_BIT     = 3;
	localparam int          PAUSE_BIT   = 7;
	localparam int          PW_LSB      = 8;
	localparam logic [13:0] DEVSET_MASK = 14'h3f88;
	localparam logic [13:0] DEVSET_RST  = 14'h0000;
	localparam logic [5:0]  WD_PASSWORD = 6'h3a;
	localparam logic [11:0] PAT_RST     = 12'h000;
	localparam logic [27:0] BVAL_RST    = 28'h000_0000;

	typedef enum logic [1:0]
	{
		MODE_OFF    = 2'h0,
		MODE_MANUAL = 2'h1,
		MODE_TIMED  = 2'h2,
		MODE_AUTO   = 2'h3
	} cbs_mode_t;

	typedef enum logic [4:0]
	{
		AS_IDLE  = 5'b00001,
		AS_ON    = 5'b00010,
		AS_PAUSE = 5'b00100,
		AS_SCAN  = 5'b01000,
		AS_WAIT  = 5'b10000
	} cbs_auto_t;

	typedef struct packed
	{
		logic       enable;
		logic       inhibit;
		logic       sleep;
		logic       addr_all;
		logic       addr_match;
	} cbs_cmd_t;

	typedef struct packed
	{
		logic              valid;
		logic [11:0][12:0] volt;
	} cbs_meas_t;
endpackage

// file: core/cbs_sequencer.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cbs_sequencer
#(
	parameter int SEC_CYCLES   = cbs_pkg::SEC_CYC,
	parameter int PAUSE_CYCLES = cbs_pkg::PAUSE_CYC
)
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire cbs_pkg::cbs_cmd_t  cmd,
	input  wire logic              wake,
	input  wire cbs_pkg::cbs_meas_t meas,
	output logic      [11:0]       cell_drive,
	output logic                   sleep,
	output logic                   scan_req
);
	import cbs_pkg::*;

	localparam int SW = $clog2(SEC_CYCLES + 1);
	localparam int PW = $clog2(PAUSE_CYCLES + 1);

	function automatic logic [13:0] merge14(logic [13:0] old, logic [31:0] wd, logic [3:0] be);
		logic [13:0] r;
		r = old;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[13:8] = wd[13:8];
		return r;
	endfunction

	function automatic logic [11:0] on_secs(logic [6:0] b);
		return 12'((int'(b) + 1) * ON_STEP_S);
	endfunction

	logic              wait_ff;
	logic [31:0]       rdata_ff;
	logic [13:0]       setup_ff;
	logic [13:0]       nxt_setup;
	logic [13:0]       wdbt_ff;
	logic [13:0]       nxt_wdbt;
	logic [13:0]       devset_ff;
	logic [13:0]       nxt_devset;
	logic [11:0]       pattern_ff [0:NLOC-1];
	logic [27:0]       bval_ff [0:NCELL-1];
	logic [27:0]       nxt_bval [0:NCELL-1];
	logic [SW-1:0]     sec_cnt_ff;
	logic              sec_tick_ff;
	logic [11:0]       on_sec_ff;
	logic [2:0]        wait_sec_ff;
	logic [PW-1:0]     pause_cnt_ff;
	logic [5:0]        wd_sec_ff;
	logic              sleep_ff;
	logic              sleep_pend_ff;
	logic              scan_req_ff;
	logic [11:0]       cell_drive_ff;
	logic [11:0]       nxt_drive;
	cbs_auto_t         state_ff;
	logic [3:0]        ptr_ff;
	logic [3:0]        nxt_ptr;
	logic [31:0]       rd_val;
	logic [11:0]       active_mask;
	logic              all_zero;

	wire        wr      = avs_write & ~wait_ff;
	wire [5:0]  idx     = avs_address[7:2];
	wire [3:0]  hptr    = setup_ff[PTR_LSB +: 4];
	wire [1:0]  mode    = setup_ff[MODE_LSB +: 2];
	wire [2:0]  wait_s  = setup_ff[WAIT_LSB +: 3];
	wire        balance_enable_bit     = setup_ff[BEN_BIT];
	wire [5:0]  wdg     = wdbt_ff[WDG_LSB +: 6];
	wire [6:0]  btm     = wdbt_ff[BTM_LSB +: 7];
	wire        pause_b = devset_ff[PAUSE_BIT];
	wire        cmd_ok  = cmd.addr_all | cmd.addr_match;
	wire        wd_on   = wdg != 6'h00;
	wire        on_done = on_sec_ff >= on_secs(btm);
	wire        is_bval = idx >= IDX_BVAL_LO && idx <= IDX_BVAL_HI;
	wire [5:0]  boff    = idx - IDX_BVAL_LO;
	wire [3:0]  bcell   = boff[4:1];
	wire        auto_run   = balance_enable_bit & mode == MODE_AUTO & ~sleep_ff;
	wire        timed_run  = balance_enable_bit & mode == MODE_TIMED & ~sleep_ff;
	wire        timed_done = timed_run & on_done;
	wire        scan_fin   = state_ff == AS_SCAN & meas.valid;
	wire        auto_done  = auto_run & scan_fin & all_zero;
	wire        wd_expire  = wd_on & sec_tick_ff & wd_sec_ff >= wdg;
	wire        sleep_cmd  = cmd_ok & cmd.sleep;
	wire        sleep_enter = wd_expire | (sleep_cmd & ~(auto_run & ~wd_on))
		| (sleep_pend_ff & ~auto_run);

	assign avs_readdata    = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign cell_drive      = cell_drive_ff;
	assign sleep           = sleep_ff;
	assign scan_req        = scan_req_ff;

	// One wait state: request seen, then answered on the next edge
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wait_ff <= 1'b1;
		else
			wait_ff <= ~((avs_read | avs_write) & wait_ff);
	end

	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (idx == IDX_SETUP)
			rd_val[13:0] = setup_ff;
		else if (idx == IDX_PATTERN)
			rd_val[11:0] = hptr < 4'(NLOC) ? pattern_ff[hptr] : PAT_RST;
		else if (idx == IDX_WDBT)
			rd_val[13:0] = wdbt_ff;
		else if (idx == IDX_DEVSET)
			rd_val[13:0] = devset_ff;
		else if (is_bval)
			rd_val[13:0] = boff[0] ? bval_ff[bcell][27:14] : bval_ff[bcell][13:0];
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata_ff <= 32'h0000_0000;
		else if (avs_read & wait_ff)
			rdata_ff <= rd_val;
	end

	always_comb
	begin
		nxt_setup = setup_ff;
		if (wr && idx == IDX_SETUP)
			nxt_setup = merge14(setup_ff, avs_writedata, avs_byteenable) & SETUP_MASK;
		if (cmd_ok & cmd.inhibit)
			nxt_setup[BEN_BIT] = 1'b0;
		if (cmd_ok & cmd.enable)
			nxt_setup[BEN_BIT] = 1'b1;
		if (timed_done | auto_done)
			nxt_setup[BEN_BIT] = 1'b0;
	end

	always_comb
	begin
		nxt_wdbt = wdbt_ff;
		if (wr && idx == IDX_WDBT)
		begin
			nxt_wdbt = merge14(wdbt_ff, avs_writedata, avs_byteenable);
			// Zero timeout only after the password
			if (nxt_wdbt[WDG_LSB +: 6] == 6'h00 && devset_ff[PW_LSB +: 6] != WD_PASSWORD)
				nxt_wdbt[WDG_LSB +: 6] = wdg;
			nxt_wdbt[WDX_BIT] = wdbt_ff[WDX_BIT] & ~(avs_byteenable[0] & avs_writedata[WDX_BIT]);
		end
		if (wd_expire)
			nxt_wdbt[WDX_BIT] = 1'b1;
	end

	always_comb
	begin
		nxt_devset = devset_ff;
		if (wr && idx == IDX_DEVSET)
			nxt_devset = merge14(devset_ff, avs_writedata, avs_byteenable) & DEVSET_MASK;
		if (timed_done | auto_done)
			nxt_devset[EOB_BIT] = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			setup_ff  <= SETUP_RST;
			wdbt_ff   <= WDBT_RST;
			devset_ff <= DEVSET_RST;
		end
		else
		begin
			setup_ff  <= nxt_setup;
			wdbt_ff   <= nxt_wdbt;
			devset_ff <= nxt_devset;
		end
	end

	// Pattern store; location 0 for manual and timed, 1..12 for auto
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NLOC; i++)
				pattern_ff[i] <= PAT_RST;
		end
		else if (wr && idx == IDX_PATTERN && hptr < 4'(NLOC) && avs_byteenable[0])
		begin
			pattern_ff[hptr][7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				pattern_ff[hptr][11:8] <= avs_writedata[11:8];
		end
	end

	// Cells still short of target in the current pattern
	always_comb
	begin
		active_mask = 12'h000;
		for (int i = 0; i < NCELL; i++)
			active_mask[i] = pattern_ff[ptr_ff][i] & (bval_ff[i] != BVAL_RST);
	end

	always_comb
	begin
		all_zero = 1'b1;
		for (int i = 0; i < NCELL; i++)
		begin
			nxt_bval[i] = bval_ff[i];
			if (scan_fin && active_mask[i])
				nxt_bval[i] = bval_ff[i] > 28'(meas.volt[i]) ?
					bval_ff[i] - 28'(meas.volt[i]) : BVAL_RST;
			if (nxt_bval[i] != BVAL_RST)
				all_zero = 1'b0;
		end
		if (wr && is_bval)
		begin
			if (boff[0])
				nxt_bval[bcell][27:14] = merge14(bval_ff[bcell][27:14], avs_writedata,
					avs_byteenable);
			else
				nxt_bval[bcell][13:0] = merge14(bval_ff[bcell][13:0], avs_writedata,
					avs_byteenable);
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NCELL; i++)
				bval_ff[i] <= BVAL_RST;
		end
		else
		begin
			for (int i = 0; i < NCELL; i++)
				bval_ff[i] <= nxt_bval[i];
		end
	end

	// Seconds timebase
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sec_cnt_ff  <= '0;
			sec_tick_ff <= 1'b0;
		end
		else if (sec_cnt_ff == SW'(SEC_CYCLES - 1))
		begin
			sec_cnt_ff  <= '0;
			sec_tick_ff <= 1'b1;
		end
		else
		begin
			sec_cnt_ff  <= sec_cnt_ff + SW'(1);
			sec_tick_ff <= 1'b0;
		end
	end

	// On-time counter; cleared whenever not balancing
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			on_sec_ff <= 12'h000;
		else if (!(timed_run || (auto_run && state_ff == AS_ON)))
			on_sec_ff <= 12'h000;
		else if (sec_tick_ff && !on_done)
			on_sec_ff <= on_sec_ff + 12'h001;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wait_sec_ff <= 3'h0;
		else if (state_ff != AS_WAIT)
			wait_sec_ff <= 3'h0;
		else if (sec_tick_ff && wait_sec_ff != wait_s)
			wait_sec_ff <= wait_sec_ff + 3'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			pause_cnt_ff <= '0;
		else if (state_ff != AS_PAUSE)
			pause_cnt_ff <= '0;
		else
			pause_cnt_ff <= pause_cnt_ff + PW'(1);
	end

	// Watchdog restarts on host writes and addressed commands
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			wd_sec_ff <= 6'h00;
		else if (wr || cmd_ok || wd_expire || !wd_on)
			wd_sec_ff <= 6'h00;
		else if (sec_tick_ff)
			wd_sec_ff <= wd_sec_ff + 6'h01;
	end

	always_comb
	begin
		if (ptr_ff >= 4'(NCELL) || pattern_ff[ptr_ff + 4'h1] == PAT_RST)
			nxt_ptr = 4'h1;
		else
			nxt_ptr = ptr_ff + 4'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= AS_IDLE;
			ptr_ff   <= 4'h1;
		end
		else if (!auto_run || auto_done)
		begin
			state_ff <= AS_IDLE;
			ptr_ff   <= 4'h1;
		end
		else
		begin
			case (state_ff)
				AS_IDLE:
					state_ff <= AS_ON;
				AS_ON:
					if (on_done)
						state_ff <= pause_b ? AS_PAUSE : AS_SCAN;
				AS_PAUSE:
					if (pause_cnt_ff == PW'(PAUSE_CYCLES - 1))
						state_ff <= AS_SCAN;
				AS_SCAN:
					if (meas.valid)
					begin
						state_ff <= AS_WAIT;
						ptr_ff   <= nxt_ptr;
					end
				AS_WAIT:
					if (wait_sec_ff == wait_s)
						state_ff <= AS_ON;
				default:
					state_ff <= AS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			scan_req_ff <= 1'b0;
		else
			scan_req_ff <= auto_run && ((state_ff == AS_ON && on_done && !pause_b)
				|| (state_ff == AS_PAUSE && pause_cnt_ff == PW'(PAUSE_CYCLES - 1)));
	end

	// Sleep entry; auto with watchdog off finishes first
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			sleep_pend_ff <= 1'b0;
		else if (sleep_enter)
			sleep_pend_ff <= 1'b0;
		else if (sleep_cmd && auto_run && !wd_on)
			sleep_pend_ff <= 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			sleep_ff <= 1'b0;
		else if (sleep_enter)
			sleep_ff <= 1'b1;
		else if (wake)
			sleep_ff <= 1'b0;
	end

	always_comb
	begin
		nxt_drive = 12'h000;
		case (mode)
			MODE_MANUAL:
				nxt_drive = balance_enable_bit ? pattern_ff[0] : 12'h000;
			MODE_TIMED:
				nxt_drive = balance_enable_bit && !on_done ? pattern_ff[0] : 12'h000;
			MODE_AUTO:
				if (state_ff == AS_ON || (state_ff == AS_SCAN && !pause_b))
					nxt_drive = active_mask;
			default:
				nxt_drive = 12'h000;
		endcase
		if (sleep_ff || sleep_enter)
			nxt_drive = 12'h000;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cell_drive_ff <= 12'h000;
		else
			cell_drive_ff <= nxt_drive;
	end

	sequence s_timed_end;
		timed_done;
	endsequence

	sequence s_ended;
		!balance_enable_bit && devset_ff[EOB_BIT] && cell_drive_ff == 12'h000;
	endsequence

	property p_sleep_off;
		@(posedge clock) disable iff (!rst_n)
		sleep_ff |=> cell_drive_ff == 12'h000;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("drive while asleep");

	property p_manual;
		@(posedge clock) disable iff (!rst_n)
		mode == MODE_MANUAL && balance_enable_bit && !sleep_ff && !sleep_enter
			|=> cell_drive_ff == $past(pattern_ff[0]);
	endproperty
	a_manual: assert property (p_manual) else $error("manual drive wrong");

	property p_timed_end;
		@(posedge clock) disable iff (!rst_n)
		s_timed_end ##1 1'b1 |-> s_ended;
	endproperty
	a_timed_end: assert property (p_timed_end) else $error("timed end wrong");

	property p_auto_start;
		@(posedge clock) disable iff (!rst_n)
		$rose(auto_run) |-> ptr_ff == 4'h1 ##1 state_ff == AS_ON;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("auto start wrong");

	property p_wrap;
		@(posedge clock) disable iff (!rst_n)
		auto_run && scan_fin && !all_zero && pattern_ff[ptr_ff + 4'h1] == PAT_RST
			|=> ptr_ff == 4'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap on zero pattern");

	property p_pause;
		@(posedge clock) disable iff (!rst_n)
		state_ff == AS_PAUSE |=> cell_drive_ff == 12'h000;
	endproperty
	a_pause: assert property (p_pause) else $error("drive during pause");

	property p_pw;
		@(posedge clock) disable iff (!rst_n)
		wr && idx == IDX_WDBT && avs_byteenable[0] && avs_writedata[5:0] == 6'h00
			&& devset_ff[PW_LSB +: 6] != WD_PASSWORD |=> wdg == $past(wdg);
	endproperty
	a_pw: assert property (p_pw) else $error("watchdog off without password");

	property p_cmd_en;
		@(posedge clock) disable iff (!rst_n)
		cmd.addr_all && cmd.enable && !timed_done && !auto_done |=> balance_enable_bit;
	endproperty
	a_cmd_en: assert property (p_cmd_en) else $error("broadcast enable lost");

	property p_wd_exp;
		@(posedge clock) disable iff (!rst_n)
		wd_expire |=> sleep_ff && wdbt_ff[WDX_BIT] ##1 cell_drive_ff == 12'h000;
	endproperty
	a_wd_exp: assert property (p_wd_exp) else $error("watchdog expiry wrong");

	property p_auto_end;
		@(posedge clock) disable iff (!rst_n)
		auto_done |=> !balance_enable_bit && devset_ff[EOB_BIT] && state_ff == AS_IDLE;
	endproperty
	a_auto_end: assert property (p_auto_end) else $error("auto end wrong");
endmodule

// file: dv/cbs_host_model.sv
`timescale 1ns/1ps
module cbs_host_model
(
	input  wire logic         clock,
	output logic [7:0]        avs_address,
	output logic              avs_read,
	output logic              avs_write,
	output logic [31:0]       avs_writedata,
	output logic [3:0]        avs_byteenable,
	input  wire logic [31:0]  avs_readdata,
	input  wire logic         avs_waitrequest,
	output cbs_pkg::cbs_cmd_t  cmd,
	output logic              wake,
	output cbs_pkg::cbs_meas_t meas,
	input  wire logic [11:0]  cell_drive,
	input  wire logic         scan_req
);
	import cbs_pkg::*;
	logic [12:0] volt_v;
	logic [11:0] seen_q[$];

	initial
	begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		cmd = '0;
		wake = 1'b0;
		meas = '0;
		volt_v = 13'h0001;
	end

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr_en, input logic [5:0] idx, input logic [13:0] wd,
		output logic [13:0] rdata);
		@(posedge clock);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {18'h0_0000, wd};
		avs_byteenable <= 4'hf;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata[13:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [13:0] wd);
		logic [13:0] d;
		bus(1'b1, idx, wd, d);
	endtask

	task automatic rd(input logic [5:0] idx, output logic [13:0] d);
		bus(1'b0, idx, 14'h0000, d);
	endtask

	task automatic send(input logic en, input logic inh, input logic slp, input logic all,
		input logic match);
		@(posedge clock);
		cmd <= '{enable: en, inhibit: inh, sleep: slp, addr_all: all, addr_match: match};
		@(posedge clock);
		cmd <= '0;
	endtask

	task automatic wake_up;
		@(posedge clock);
		wake <= 1'b1;
		@(posedge clock);
		wake <= 1'b0;
	endtask

	// Scan answer after a random delay; idle voltage lines show the inverse
	initial
	begin
		forever
		begin
			@(posedge clock);
			if (scan_req === 1'b1)
			begin
				seen_q.push_back(cell_drive);
				repeat (1 + $urandom_range(5)) @(posedge clock);
				meas <= {1'b1, {12{volt_v}}};
				@(posedge clock);
				meas <= {1'b0, {12{~volt_v}}};
			end
		end
	end
endmodule

// file: dv/tb_cell_balance_sequencer.sv
`timescale 1ns/1ps
module tb_cell_balance_sequencer;
	import cbs_pkg::*;
	localparam int SECS = 20;
	logic               clock;
	logic               rst_n;
	logic [7:0]         avs_address;
	logic               avs_read;
	logic               avs_write;
	logic [31:0]        avs_writedata;
	logic [3:0]         avs_byteenable;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	cbs_cmd_t           cmd;
	logic               wake;
	cbs_meas_t          meas;
	logic [11:0]        cell_drive;
	logic               sleep;
	logic               scan_req;
	int                 err_count = 0;
	int                 checks_done = 0;
	int                 cyc = 0;
	int                 t;
	logic [13:0]        rv;
	logic [11:0]        pat;
	logic [6:0]         ot;

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	cbs_sequencer #(.SEC_CYCLES(SECS), .PAUSE_CYCLES(5)) dut (.clock(clock), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd(cmd),
		.wake(wake), .meas(meas), .cell_drive(cell_drive), .sleep(sleep), .scan_req(scan_req));

	cbs_host_model host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd(cmd),
		.wake(wake), .meas(meas), .cell_drive(cell_drive), .scan_req(scan_req));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [13:0] setup_w(input logic [1:0] m, input logic [2:0] w,
		input logic [3:0] p, input logic en);
		return {4'h0, en, p, w, m};
	endfunction

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Auto run: loc1 even cells, loc2 odd cells, loc3 empty; each cell needs two scans
	task automatic run_auto(input logic pz);
		logic [12:0] v;
		logic [11:0] e;
		v = 13'($urandom_range(1, 4095));
		host.volt_v = v;
		for (int i = 1; i <= 3; i++)
		begin
			host.wr(IDX_SETUP, setup_w(MODE_OFF, 3'h0, 4'(i), 1'b0));
			host.wr(IDX_PATTERN, (i == 1) ? 14'h0555 : (i == 2) ? 14'h0aaa : 14'h0000);
		end
		for (int n = 0; n < 12; n++)
		begin
			host.wr(IDX_BVAL_LO + 6'(2 * n), {v, 1'b0});
			host.wr(IDX_BVAL_LO + 6'(2 * n + 1), 14'h0000);
		end
		host.wr(IDX_DEVSET, {6'h00, pz, 7'h00});
		host.wr(IDX_WDBT, 14'h0000);
		host.seen_q.delete();
		host.wr(IDX_SETUP, setup_w(MODE_AUTO, 3'($urandom_range(1)), 4'h0, 1'b1));
		rv = 14'h0200;
		for (int k = 0; k < 100 && rv[BEN_BIT] !== 1'b0; k++)
		begin
			idle(50);
			host.rd(IDX_SETUP, rv);
		end
		chk(32'(host.seen_q.size()), 32'd4, "auto cycle count");
		foreach (host.seen_q[k])
		begin
			e = pz ? 12'h000 : (k % 2) ? 12'haaa : 12'h555;
			chk(host.seen_q[k], e, "auto drive at scan");
		end
		host.rd(IDX_DEVSET, rv);
		chk(rv[EOB_BIT], 1'b1, "auto end flag");
		chk(cell_drive, 12'h000, "auto done drive");
		$display("test auto pause=%0d done", pz);
	endtask

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			$display("wrong value at %0t: run did not finish in time", $time);
			summarize();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		void'($urandom(32'haae7));
		idle(4);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			host.rd(i == 0 ? IDX_SETUP : i == 1 ? IDX_WDBT : i == 2 ? IDX_DEVSET : 6'h3f, rv);
			chk(rv, 14'h0000, "reset value");
		end
		host.wr(6'h3f, 14'($urandom));
		host.rd(6'h3f, rv);
		chk(rv, 14'h0000, "unmapped read");
		pat = 12'($urandom) & 12'hdff;
		host.wr(IDX_SETUP, {2'b00, pat});
		host.rd(IDX_SETUP, rv);
		chk(rv, {2'b00, pat} & SETUP_MASK, "setup readback");
		$display("test registers done");

		pat = 12'($urandom_range(1, 4095));
		host.wr(IDX_SETUP, setup_w(MODE_OFF, 3'h0, 4'h0, 1'b0));
		host.wr(IDX_PATTERN, {2'b00, pat});
		host.wr(IDX_SETUP, setup_w(MODE_MANUAL, 3'h0, 4'h0, 1'b1));
		idle(3);
		chk(cell_drive, pat, "manual on");
		host.send(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		idle(3);
		chk(cell_drive, 12'h000, "broadcast inhibit");
		host.send(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		idle(3);
		chk(cell_drive, 12'h000, "unaddressed enable");
		host.send(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		idle(3);
		chk(cell_drive, pat, "enable command");
		host.wr(IDX_SETUP, setup_w(MODE_OFF, 3'h0, 4'h0, 1'b1));
		idle(3);
		chk(cell_drive, 12'h000, "no mode");
		host.wr(IDX_SETUP, setup_w(MODE_MANUAL, 3'h0, 4'h0, 1'b0));
		idle(3);
		chk(cell_drive, 12'h000, "enable cleared");
		host.wr(IDX_SETUP, setup_w(MODE_MANUAL, 3'h0, 4'h0, 1'b1));
		host.send(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		idle(3);
		chk({sleep, cell_drive}, {1'b1, 12'h000}, "sleep stops");
		host.wake_up();
		idle(2);
		chk(sleep, 1'b0, "wake");
		$display("test manual done");

		host.wr(IDX_WDBT, 14'h0002);
		host.wr(IDX_SETUP, setup_w(MODE_MANUAL, 3'h0, 4'h0, 1'b1));
		host.send(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
		idle(3);
		chk({sleep, cell_drive}, {1'b1, 12'h000}, "sleep with watchdog");
		host.rd(IDX_WDBT, rv);
		chk(rv[WDX_BIT], 1'b0, "expired too early");
		idle(80);
		host.rd(IDX_WDBT, rv);
		chk(rv[WDX_BIT], 1'b1, "expired later");
		// Restart the watchdog before waking, so no expiry slips in
		host.wr(IDX_WDBT, 14'h0042);
		host.wake_up();
		host.wr(IDX_SETUP, setup_w(MODE_MANUAL, 3'h0, 4'h0, 1'b1));
		idle(3);
		chk(cell_drive, pat, "manual again");
		idle(80);
		chk({sleep, cell_drive}, {1'b1, 12'h000}, "watchdog timeout");
		host.wr(IDX_DEVSET, 14'h1500);
		host.wr(IDX_WDBT, 14'h0000);
		host.rd(IDX_WDBT, rv);
		chk(rv[5:0], 6'h02, "zero without password");
		host.wr(IDX_DEVSET, {WD_PASSWORD, 8'h00});
		host.rd(IDX_DEVSET, rv);
		chk(rv[13:8], WD_PASSWORD, "password readback");
		host.wr(IDX_WDBT, 14'h0000);
		host.rd(IDX_WDBT, rv);
		chk(rv[5:0], 6'h00, "watchdog disabled");
		// Wake only once the watchdog is off
		host.wake_up();
		idle(80);
		chk(sleep, 1'b0, "no expiry when off");
		$display("test watchdog done");

		ot = 7'($urandom_range(1));
		t = (ot + 1) * 20 * SECS;
		host.wr(IDX_SETUP, setup_w(MODE_OFF, 3'h0, 4'h0, 1'b0));
		host.wr(IDX_WDBT, {ot, 7'h00});
		host.wr(IDX_SETUP, setup_w(MODE_TIMED, 3'h0, 4'h0, 1'b1));
		idle(t / 2);
		host.wr(IDX_SETUP, setup_w(MODE_TIMED, 3'h0, 4'h0, 1'b0));
		idle(3);
		chk(cell_drive, 12'h000, "timed disable");
		host.send(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		idle(t - 40);
		chk(cell_drive, pat, "timed still on");
		idle(80);
		chk(cell_drive, 12'h000, "timed expired");
		host.rd(IDX_DEVSET, rv);
		chk(rv[EOB_BIT], 1'b1, "timed end flag");
		host.rd(IDX_SETUP, rv);
		chk(rv[BEN_BIT], 1'b0, "timed enable cleared");
		$display("test timed done");

		run_auto(1'b0);
		run_auto(1'b1);
		summarize();
	end
endmodule
